// File: lrh_defines.svh
// Constants for the loader request handler
`ifndef LRH_DEFINES_SVH
`define LRH_DEFINES_SVH
// Request codes written by the controller
`define LRH_REQ_NONE       16'h0000
`define LRH_REQ_BLANKET    16'h0100
`define LRH_REQ_POLL1      16'h0200
`define LRH_REQ_POLL2      16'h0300
`define LRH_REQ_SEL1       16'h0400
`define LRH_REQ_SEL2       16'h0500
`define LRH_REQ_RANDOM_HI  8'h06
// Error codes placed in the response status word
`define LRH_NEGATIVE_ACK_ERROR     16'hff00
`define LRH_UNKNOWN_COMMAND_ERROR  16'hff01
`define LRH_EMPTY_POLL_ERROR       16'hff02
`define LRH_BAD_REQUEST_ERROR      16'hff03
`define LRH_OUTPUT_UNDERRUN_ERROR  16'hff04
`define LRH_INPUT_OVERFLOW_ERROR   16'hff05
`define LRH_POLL_LENGTH_ERROR      16'hff06
// Input word positions
`define LRH_IDX_STATUS     4'h0
`define LRH_IDX_ERR_CMD    4'h1
`define LRH_IDX_ERR_LEN    4'h2
`define LRH_IDX_FIRST_RES  4'h1
// Output word positions
`define LRH_IDX_FIRST_PAR  4'h1
`define LRH_IDX_RND_DATA   4'h2
`define LRH_IDX_BLK_DATA   4'h1
// Words reserved ahead of select and poll data
`define LRH_RND_OUT_RSV    8'h02
`define LRH_BLK_OUT_RSV    8'h01
`define LRH_IN_RSV         8'h01
// Blanket poll command list, other known commands and standard lengths
`define LRH_BLANKET_CNT    2'h3
`define LRH_CMD_LOAD_A     16'h2050
`define LRH_CMD_LOAD_B     16'h2052
`define LRH_CMD_PROC_ST    16'h2040
`define LRH_CMD_MAT_MODE   16'h2048
`define LRH_CMD_MAT_SET    16'h2049
`define LRH_CMD_LOAD_A_SET 16'h2051
`define LRH_LEN_VALUE      8'h04
`define LRH_LEN_STATUS     8'h02
`define LRH_LEN_CMD_WORD   8'h02
`endif

// File: lrh_pkg.sv
// Types for the loader request handler
`default_nettype none
package lrh_pkg;
  // One-hot sequencer states
  typedef enum logic [5:0] {
    LRH_IDLE   = 6'b000001,
    LRH_DECODE = 6'b000010,
    LRH_CHECK  = 6'b000100,
    LRH_SEND   = 6'b001000,
    LRH_XFER   = 6'b010000,
    LRH_EVAL   = 6'b100000
  } lrh_state_t;
  // Kind of request being executed
  typedef enum logic [1:0] {
    LRH_M_BLANKET = 2'h0,
    LRH_M_BLOCK   = 2'h1,
    LRH_M_RANDOM  = 2'h2
  } lrh_mode_t;
endpackage
`default_nettype wire

// File: lrh_handler.sv
// Loader request handler: request decode, sequencing, result and error words
`timescale 1ns/1ps
`default_nettype none
`include "lrh_defines.svh"
////////////////////////////////////////////////////////////////////////////////
module lrh_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input  wire logic         i_clock,
  input  wire logic         i_resetn,
  input  wire logic         i_ce,
  input  wire logic         i_in_valid,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_in_ready,
  output logic              o_out_valid,
  output logic [W-1:0]      o_out_data,
  input  wire logic         i_out_ready
);
  localparam int AW = $clog2(D);
  localparam logic [AW:0] FULL = D[AW:0];
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0]   cnt_r;
  logic [AW:0]   cnt_nxt;
  logic          rdy_r;
  logic          vld_r;
  wire           push = i_in_valid & rdy_r;
  wire           pop  = vld_r & i_out_ready;
  // Flags registered from the next count so both stay honest
  assign cnt_nxt     = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign o_in_ready  = rdy_r;
  assign o_out_valid = vld_r;
  assign o_out_data  = mem[rp_r];
  // Pointer and flag update
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
      rdy_r <= 1'b0;
      vld_r <= 1'b0;
    end else if (i_ce) begin
      if (push) wp_r <= wp_r + 1'b1;
      if (pop) rp_r <= rp_r + 1'b1;
      cnt_r <= cnt_nxt;
      rdy_r <= (cnt_nxt != FULL);
      vld_r <= (cnt_nxt != '0);
    end
  end
  // Storage needs no reset
  always_ff @(posedge i_clock) begin
    if (i_ce && push) mem[wp_r] <= i_in_data;
  end
endmodule
////////////////////////////////////////////////////////////////////////////////
module lrh_handler import lrh_pkg::*; #(
  parameter int N_IN   = 10,
  parameter int N_OUT  = 12,
  parameter int BLK_D  = 8,
  parameter int FIFO_D = 16
) (
  input  wire logic        i_clock,
  input  wire logic        i_resetn,
  input  wire logic        i_ce,
  input  wire logic        i_out_wr,
  input  wire logic [3:0]  i_out_idx,
  input  wire logic [15:0] i_out_data,
  input  wire logic [3:0]  i_in_idx,
  output logic      [15:0] o_in_data,
  input  wire logic        i_cfg_wr,
  input  wire logic [1:0]  i_cfg_blk,
  input  wire logic [2:0]  i_cfg_ent,
  input  wire logic [15:0] i_cfg_cmd,
  input  wire logic [7:0]  i_cfg_len,
  output logic             o_lnk_req,
  output logic      [15:0] o_lnk_cmd,
  output logic      [7:0]  o_lnk_len,
  output logic             o_lnk_sel,
  input  wire logic        i_lnk_ack,
  output logic             o_tx_valid,
  output logic      [7:0]  o_tx_byte,
  input  wire logic        i_tx_ready,
  input  wire logic        i_rx_valid,
  input  wire logic [7:0]  i_rx_byte,
  output logic             o_rx_ready,
  input  wire logic        i_lnk_done,
  input  wire logic        i_lnk_nak,
  output logic             o_busy
);
  // Byte capacities of the word buffers
  localparam logic [7:0] IN_CAP  = 8'((N_IN - 1) * 2);
  localparam logic [7:0] RND_CAP = 8'((N_OUT - 2) * 2);
  localparam logic [7:0] BLK_CAP = 8'((N_OUT - 1) * 2);
  logic [15:0] out_w [N_OUT];
  logic [15:0] in_w  [N_IN];
  logic [15:0] cfg_cmd [4*BLK_D];
  logic [7:0]  cfg_len [4*BLK_D];
  lrh_state_t  st_r;
  lrh_mode_t   mode_r;
  logic [15:0] status_r;
  logic [15:0] req_r;
  logic        armed_r;
  logic [1:0]  blk_r;
  logic [2:0]  ent_r;
  logic [7:0]  iptr_r;
  logic [7:0]  optr_r;
  logic [7:0]  rx_cnt_r;
  logic [7:0]  tx_left_r;
  logic        done_r;
  logic        nak_r;
  logic        err_wr_r;
  logic [15:0] err_cmd_r;
  logic [7:0]  err_len_r;
  logic        fifo_vld;
  logic [7:0]  fifo_byte;
  logic        fifo_pop;
  // Receive bytes are queued so the link can run ahead of the buffer writes
  lrh_fifo #(.W(8), .D(FIFO_D)) u_rx_fifo (
    .i_clock     (i_clock),
    .i_resetn    (i_resetn),
    .i_ce        (i_ce),
    .i_in_valid  (i_rx_valid),
    .i_in_data   (i_rx_byte),
    .o_in_ready  (o_rx_ready),
    .o_out_valid (fifo_vld),
    .o_out_data  (fifo_byte),
    .i_out_ready (fifo_pop)
  );
  // Request decode
  wire [15:0] req_in   = out_w[0];
  wire        is_blank = (req_r == `LRH_REQ_BLANKET);
  wire        is_p1    = (req_r == `LRH_REQ_POLL1);
  wire        is_p2    = (req_r == `LRH_REQ_POLL2);
  wire        is_s1    = (req_r == `LRH_REQ_SEL1);
  wire        is_s2    = (req_r == `LRH_REQ_SEL2);
  wire        is_rnd   = (req_r[15:8] == `LRH_REQ_RANDOM_HI);
  wire        is_blk   = is_p1 | is_p2 | is_s1 | is_s2;
  wire [1:0]  blk_sel  = {is_s1 | is_s2, is_p2 | is_s2};
  // Current command: blanket list, block entry or parameter word
  wire [4:0]  cfg_a    = {blk_r, ent_r};
  wire [15:0] blank_cmd = (ent_r == 3'h0) ? `LRH_CMD_LOAD_A :
                          (ent_r == 3'h1) ? `LRH_CMD_LOAD_B : `LRH_CMD_PROC_ST;
  wire [15:0] cur_cmd  = (mode_r == LRH_M_BLOCK)  ? cfg_cmd[cfg_a] :
                         (mode_r == LRH_M_RANDOM) ? out_w[`LRH_IDX_FIRST_PAR]
                                                  : blank_cmd;
  wire [7:0]  given_len = (mode_r == LRH_M_BLOCK)  ? cfg_len[cfg_a] :
                          (mode_r == LRH_M_RANDOM) ? req_r[7:0] : 8'h00;
  // Standard lengths; anything else needs an explicit length
  wire [7:0]  std_len  = (cur_cmd == `LRH_CMD_LOAD_A)     ? `LRH_LEN_VALUE :
                         (cur_cmd == `LRH_CMD_LOAD_B)     ? `LRH_LEN_VALUE :
                         (cur_cmd == `LRH_CMD_LOAD_A_SET) ? `LRH_LEN_VALUE :
                         (cur_cmd == `LRH_CMD_PROC_ST)    ? `LRH_LEN_STATUS :
                         (cur_cmd == `LRH_CMD_MAT_MODE)   ? `LRH_LEN_STATUS :
                         (cur_cmd == `LRH_CMD_MAT_SET)    ? `LRH_LEN_STATUS : 8'h00;
  wire [7:0]  cur_len  = (given_len != 8'h00) ? given_len : std_len;
  wire        cur_sel  = cur_cmd[0]; // Odd second command byte writes
  wire [7:0]  hdr_len  = (mode_r == LRH_M_BLANKET) ? `LRH_LEN_CMD_WORD : 8'h00;
  wire [8:0]  in_need  = {1'b0, iptr_r} + {1'b0, cur_len} + {1'b0, hdr_len};
  wire [8:0]  out_need = {1'b0, optr_r} + {1'b0, cur_len};
  wire [7:0]  out_cap  = (mode_r == LRH_M_RANDOM) ? RND_CAP : BLK_CAP;
  wire        in_ovf   = in_need > {1'b0, IN_CAP};
  wire        out_unr  = out_need > {1'b0, out_cap};
  // Next entry of the running list
  wire [2:0]  ent_nx   = ent_r + 3'h1;
  wire        more     = (mode_r == LRH_M_BLANKET) ? (ent_nx < {1'b0, `LRH_BLANKET_CNT}) :
                         (mode_r == LRH_M_BLOCK)   ? ((ent_r != 3'(BLK_D - 1)) &&
                                                      (cfg_cmd[{blk_r, ent_nx}] != 16'h0000))
                                                   : 1'b0;
  // Select source byte and poll destination word
  wire [7:0]  obase    = (mode_r == LRH_M_RANDOM) ? `LRH_RND_OUT_RSV : `LRH_BLK_OUT_RSV;
  wire [7:0]  oword    = obase + {1'b0, optr_r[7:1]};
  wire [15:0] osrc     = out_w[oword[3:0]];
  wire [7:0]  tx_pick  = optr_r[0] ? osrc[7:0] : osrc[15:8];
  wire [7:0]  iword    = `LRH_IN_RSV + {1'b0, iptr_r[7:1]};
  wire        in_room  = iptr_r < IN_CAP;
  wire        tx_go    = (st_r == LRH_XFER) && (tx_left_r != 8'h00) &&
                         (!o_tx_valid || i_tx_ready);
  assign fifo_pop = (st_r == LRH_XFER) && fifo_vld;
  wire        xfer_end = done_r && !fifo_vld && (tx_left_r == 8'h00) &&
                         !(o_tx_valid && !i_tx_ready);
  // Controller output words and block configuration
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      for (int k = 0; k < N_OUT; k++) out_w[k] <= 16'h0000;
    end else if (i_ce && i_out_wr && ({28'h0, i_out_idx} < N_OUT)) begin
      out_w[i_out_idx] <= i_out_data;
    end
  end
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      for (int k = 0; k < 4*BLK_D; k++) cfg_cmd[k] <= 16'h0000;
    end else if (i_ce && i_cfg_wr) begin
      cfg_cmd[{i_cfg_blk, i_cfg_ent}] <= i_cfg_cmd;
    end
  end
  always_ff @(posedge i_clock) begin
    if (i_ce && i_cfg_wr) cfg_len[{i_cfg_blk, i_cfg_ent}] <= i_cfg_len;
  end
  // Result words; error details overwrite the first two
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      for (int k = 0; k < N_IN; k++) in_w[k] <= 16'h0000;
    end else if (i_ce) begin
      if (err_wr_r) begin
        in_w[`LRH_IDX_ERR_CMD] <= err_cmd_r;
        in_w[`LRH_IDX_ERR_LEN] <= {err_len_r, 8'h00};
      end else if (st_r == LRH_CHECK && mode_r == LRH_M_BLANKET && !in_ovf && cur_len != 8'h00) begin
        in_w[iword[3:0]] <= cur_cmd;
      end else if (fifo_pop && in_room) begin
        if (iptr_r[0]) in_w[iword[3:0]][7:0] <= fifo_byte;
        else in_w[iword[3:0]][15:8] <= fifo_byte;
      end
    end
  end
  // Read port toward the controller
  always_ff @(posedge i_clock) begin
    if (!i_resetn) o_in_data <= 16'h0000;
    else if (i_ce) o_in_data <= (i_in_idx == `LRH_IDX_STATUS) ? status_r : in_w[i_in_idx];
  end
  // Sequencer
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      st_r <= LRH_IDLE;
      mode_r <= LRH_M_BLANKET;
      status_r <= 16'h0000;
      req_r <= 16'h0000;
      armed_r <= 1'b0;
      blk_r <= 2'h0;
      ent_r <= 3'h0;
      iptr_r <= 8'h00;
      optr_r <= 8'h00;
      rx_cnt_r <= 8'h00;
      tx_left_r <= 8'h00;
      done_r <= 1'b0;
      nak_r <= 1'b0;
      err_wr_r <= 1'b0;
      err_cmd_r <= 16'h0000;
      err_len_r <= 8'h00;
      o_lnk_req <= 1'b0;
      o_lnk_cmd <= 16'h0000;
      o_lnk_len <= 8'h00;
      o_lnk_sel <= 1'b0;
      o_tx_valid <= 1'b0;
      o_tx_byte <= 8'h00;
      o_busy <= 1'b0;
    end else if (i_ce) begin
      err_wr_r <= 1'b0;
      if (o_tx_valid && i_tx_ready) o_tx_valid <= 1'b0;
      if (tx_go) begin
        o_tx_valid <= 1'b1;
        o_tx_byte <= tx_pick;
        optr_r <= optr_r + 8'h01;
        tx_left_r <= tx_left_r - 8'h01;
      end
      if (fifo_pop) begin
        rx_cnt_r <= rx_cnt_r + 8'h01;
        iptr_r <= iptr_r + 8'h01;
      end
      if (st_r == LRH_XFER && i_lnk_done) begin
        done_r <= 1'b1;
        nak_r <= i_lnk_nak;
      end
      case (st_r)
        LRH_IDLE: begin
          if (req_in == `LRH_REQ_NONE) begin
            status_r <= 16'h0000;
            armed_r <= 1'b1;
          end else if (armed_r) begin
            armed_r <= 1'b0;
            req_r <= req_in;
            o_busy <= 1'b1;
            st_r <= LRH_DECODE;
          end
        end
        LRH_DECODE: begin
          ent_r <= 3'h0;
          blk_r <= blk_sel;
          iptr_r <= 8'h00;
          optr_r <= 8'h00;
          mode_r <= is_blk ? LRH_M_BLOCK : is_rnd ? LRH_M_RANDOM : LRH_M_BLANKET;
          if (!(is_blank || is_blk || is_rnd) || (is_blk && cfg_cmd[{blk_sel, 3'h0}] == 16'h0000)) begin
            status_r <= `LRH_BAD_REQUEST_ERROR;
            o_busy <= 1'b0;
            st_r <= LRH_IDLE;
          end else begin
            st_r <= LRH_CHECK;
          end
        end
        LRH_CHECK: begin
          err_cmd_r <= cur_cmd;
          err_len_r <= cur_len;
          if (cur_len == 8'h00) begin
            status_r <= `LRH_UNKNOWN_COMMAND_ERROR;
            err_wr_r <= 1'b1;
            o_busy <= 1'b0;
            st_r <= LRH_IDLE;
          end else if (cur_sel ? out_unr : in_ovf) begin
            status_r <= cur_sel ? `LRH_OUTPUT_UNDERRUN_ERROR : `LRH_INPUT_OVERFLOW_ERROR;
            err_wr_r <= 1'b1;
            o_busy <= 1'b0;
            st_r <= LRH_IDLE;
          end else begin
            if (mode_r == LRH_M_BLANKET) iptr_r <= iptr_r + `LRH_LEN_CMD_WORD;
            o_lnk_req <= 1'b1;
            o_lnk_cmd <= cur_cmd;
            o_lnk_len <= cur_len;
            o_lnk_sel <= cur_sel;
            st_r <= LRH_SEND;
          end
        end
        LRH_SEND: begin
          if (i_lnk_ack) begin
            o_lnk_req <= 1'b0;
            rx_cnt_r <= 8'h00;
            done_r <= 1'b0;
            nak_r <= 1'b0;
            tx_left_r <= o_lnk_sel ? o_lnk_len : 8'h00;
            st_r <= LRH_XFER;
          end
        end
        LRH_XFER: begin
          // Drain queued bytes before judging the answer
          if (xfer_end) st_r <= LRH_EVAL;
        end
        LRH_EVAL: begin
          if (nak_r || (!o_lnk_sel && rx_cnt_r != o_lnk_len)) begin
            status_r <= nak_r ? `LRH_NEGATIVE_ACK_ERROR :
                        (rx_cnt_r == 8'h00) ? `LRH_EMPTY_POLL_ERROR :
                        `LRH_POLL_LENGTH_ERROR;
            err_wr_r <= 1'b1;
            o_busy <= 1'b0;
            st_r <= LRH_IDLE;
          end else if (more) begin
            ent_r <= ent_nx;
            st_r <= LRH_CHECK;
          end else begin
            status_r <= req_r;
            o_busy <= 1'b0;
            st_r <= LRH_IDLE;
          end
        end
        default: st_r <= LRH_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// File: lrh_handler_chk.sv
// Port-level assertions for the loader request handler
`timescale 1ns/1ps
`default_nettype none
module lrh_handler_chk (
  input wire logic        i_clock,
  input wire logic        i_resetn,
  input wire logic        i_out_wr,
  input wire logic [3:0]  i_out_idx,
  input wire logic [15:0] i_out_data,
  input wire logic [3:0]  i_in_idx,
  input wire logic [15:0] o_in_data,
  input wire logic        o_lnk_req,
  input wire logic [15:0] o_lnk_cmd,
  input wire logic [7:0]  o_lnk_len,
  input wire logic        o_lnk_sel,
  input wire logic        i_lnk_ack,
  input wire logic        o_tx_valid,
  input wire logic [7:0]  o_tx_byte,
  input wire logic        i_tx_ready,
  input wire logic        o_busy
);
  logic [15:0] req_w_r;
  // Shadow of the request word, since the word itself is not visible
  always_ff @(posedge i_clock) begin
    if (!i_resetn) req_w_r <= 16'h0000;
    else if (i_out_wr && i_out_idx == 4'h0) req_w_r <= i_out_data;
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  // Link and transfer handshakes
  lnk_hold_a:
    assert property (o_lnk_req && !i_lnk_ack |=> o_lnk_req
                     && $stable({o_lnk_cmd, o_lnk_len, o_lnk_sel}))
    else $error("link request dropped or changed before ack");
  lnk_busy_a:
    assert property (o_lnk_req || o_tx_valid |-> o_busy)
    else $error("link activity while idle");
  sel_parity_a:
    assert property (o_lnk_req |-> o_lnk_sel == o_lnk_cmd[0])
    else $error("poll or select kind does not match command");
  tx_hold_a:
    assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_byte))
    else $error("select byte withdrawn before ready");
  tx_sel_a:
    assert property (o_tx_valid |-> o_lnk_sel)
    else $error("select byte sent for a poll");
  // Request acceptance and completion
  take_nonzero_a:
    assert property ($rose(o_busy) |-> $past(req_w_r) != 16'h0000)
    else $error("request taken from a zero word");
  bad_req_a:
    assert property ($rose(o_busy) && req_w_r[15:8] == 8'h07
                     |-> (!o_lnk_req throughout (##[1:3] !o_busy)))
    else $error("bad request reached the link or hung");
  blanket_first_a:
    assert property ($rose(o_busy) && req_w_r == 16'h0100 |-> ##[1:4] o_lnk_req
                     && o_lnk_cmd == 16'h2050 && o_lnk_len == 8'h04 && !o_lnk_sel)
    else $error("blanket poll did not start with its first command");
  status_clear_a:
    assert property ((!o_busy && req_w_r == 16'h0000 && i_in_idx == 4'h0) [*3]
                     |=> o_in_data == 16'h0000)
    else $error("status not cleared by zero request");
  done_status_a:
    assert property ($fell(o_busy) && i_in_idx == 4'h0 |=> o_in_data != 16'h0000)
    else $error("completion left status at zero");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind lrh_handler lrh_handler_chk u_lrh_handler_chk (
  .i_clock(i_clock), .i_resetn(i_resetn), .i_out_wr(i_out_wr), .i_out_idx(i_out_idx),
  .i_out_data(i_out_data), .i_in_idx(i_in_idx), .o_in_data(o_in_data),
  .o_lnk_req(o_lnk_req), .o_lnk_cmd(o_lnk_cmd), .o_lnk_len(o_lnk_len),
  .o_lnk_sel(o_lnk_sel), .i_lnk_ack(i_lnk_ack), .o_tx_valid(o_tx_valid),
  .o_tx_byte(o_tx_byte), .i_tx_ready(i_tx_ready), .o_busy(o_busy)
);
`default_nettype wire

// File: lrh_loader_model.sv
// Behavioural loader at the far side of the link
`timescale 1ns/1ps
`default_nettype none
module lrh_loader_model (
  input  wire logic        i_clock,
  input  wire logic        i_resetn,
  input  wire logic        i_lnk_req,
  input  wire logic [15:0] i_lnk_cmd,
  input  wire logic [7:0]  i_lnk_len,
  input  wire logic        i_lnk_sel,
  output logic             o_lnk_ack,
  input  wire logic        i_tx_valid,
  input  wire logic [7:0]  i_tx_byte,
  output logic             o_tx_ready,
  output logic             o_rx_valid,
  output logic      [7:0]  o_rx_byte,
  input  wire logic        i_rx_ready,
  output logic             o_lnk_done,
  output logic             o_lnk_nak,
  input  wire logic [3:0]  i_slow,
  input  wire logic        i_nak,
  input  wire logic [1:0]  i_rx_mode
);
  logic [7:0] sel_q [$];
  int         n, cnt, t;
  // One command at a time; answer bytes count up from the low command byte
  initial begin
    {o_lnk_ack, o_tx_ready, o_rx_valid, o_lnk_done, o_lnk_nak} = 5'h00;
    o_rx_byte = 8'h00;
    forever begin
      @(posedge i_clock);
      if (i_resetn && i_lnk_req) begin
        repeat (i_slow) @(posedge i_clock);
        o_lnk_ack <= 1'b1;
        @(posedge i_clock);
        o_lnk_ack <= 1'b0;
        // Modes 1..3 give none, one short or one extra byte
        cnt = (i_rx_mode == 2'h1 || i_nak) ? 0 :
              int'(i_lnk_len) + int'(i_rx_mode == 2'h3) - int'(i_rx_mode == 2'h2);
        if (i_lnk_sel) begin
          o_tx_ready <= 1'b1;
          n = 0;
          t = 0;
          while (n < int'(i_lnk_len) && t < 400) begin
            @(posedge i_clock);
            t++;
            if (i_tx_valid) begin
              sel_q.push_back(i_tx_byte);
              n++;
            end
          end
          o_tx_ready <= 1'b0;
        end else begin
          for (int k = 0; k < cnt; k++) begin
            o_rx_valid <= 1'b1;
            o_rx_byte  <= i_lnk_cmd[7:0] + 8'(k);
            t = 0;
            do begin
              @(posedge i_clock);
              t++;
            end while (!i_rx_ready && t < 50);
          end
          o_rx_valid <= 1'b0;
          // Released line must not look like the last byte
          o_rx_byte  <= ~o_rx_byte;
        end
        o_lnk_done <= 1'b1;
        o_lnk_nak  <= i_nak;
        @(posedge i_clock);
        o_lnk_done <= 1'b0;
        o_lnk_nak  <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// File: lrh_handler_bench.sv
// Self-checking bench for the loader request handler
`timescale 1ns/1ps
`default_nettype none
module lrh_handler_bench;
  logic        i_clock = 1'b0;
  logic        i_resetn, out_wr, cfg_wr, lnk_req, lnk_sel, lnk_ack, nak;
  logic        tx_valid, tx_ready, rx_valid, rx_ready, lnk_done, lnk_nak, busy;
  logic [3:0]  out_idx, in_idx, slow;
  logic [15:0] out_data, in_data, cfg_cmd, lnk_cmd, v;
  logic [7:0]  cfg_len, lnk_len, tx_byte, rx_byte;
  logic [2:0]  cfg_ent;
  logic [1:0]  cfg_blk, rx_mode;
  int          bad_count, n_tests;
  logic [15:0] bl [3] = '{16'h2050, 16'h2052, 16'h2040};
  logic [7:0]  sx [10] = '{8'h12, 8'h34, 8'h56, 8'h78, 8'h9a, 8'hbc, 8'h12, 8'h34, 8'h56, 8'h78};
  always #50 i_clock = ~i_clock;
  lrh_handler u_lrh_handler (
    .i_clock(i_clock), .i_resetn(i_resetn), .i_ce(1'b1), .i_out_wr(out_wr),
    .i_out_idx(out_idx), .i_out_data(out_data), .i_in_idx(in_idx), .o_in_data(in_data),
    .i_cfg_wr(cfg_wr), .i_cfg_blk(cfg_blk), .i_cfg_ent(cfg_ent), .i_cfg_cmd(cfg_cmd),
    .i_cfg_len(cfg_len), .o_lnk_req(lnk_req), .o_lnk_cmd(lnk_cmd), .o_lnk_len(lnk_len),
    .o_lnk_sel(lnk_sel), .i_lnk_ack(lnk_ack), .o_tx_valid(tx_valid), .o_tx_byte(tx_byte),
    .i_tx_ready(tx_ready), .i_rx_valid(rx_valid), .i_rx_byte(rx_byte), .o_rx_ready(rx_ready),
    .i_lnk_done(lnk_done), .i_lnk_nak(lnk_nak), .o_busy(busy));
  lrh_loader_model u_lrh_loader_model (
    .i_clock(i_clock), .i_resetn(i_resetn), .i_lnk_req(lnk_req), .i_lnk_cmd(lnk_cmd),
    .i_lnk_len(lnk_len), .i_lnk_sel(lnk_sel), .o_lnk_ack(lnk_ack), .i_tx_valid(tx_valid),
    .i_tx_byte(tx_byte), .o_tx_ready(tx_ready), .o_rx_valid(rx_valid), .o_rx_byte(rx_byte),
    .i_rx_ready(rx_ready), .o_lnk_done(lnk_done), .o_lnk_nak(lnk_nak), .i_slow(slow),
    .i_nak(nak), .i_rx_mode(rx_mode));
  task automatic stop_test;
    if (bad_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Word writes are one-cycle pulses with a gap, never re-raised in one step
  task automatic wr(input logic [3:0] idx, input logic [15:0] d);
    @(posedge i_clock);
    out_wr   <= 1'b1;
    out_idx  <= idx;
    out_data <= d;
    @(posedge i_clock);
    out_wr <= 1'b0;
  endtask
  task automatic cfg(input logic [1:0] b, input logic [2:0] e, input logic [15:0] c);
    @(posedge i_clock);
    {cfg_wr, cfg_blk, cfg_ent, cfg_cmd, cfg_len} <= {1'b1, b, e, c, 8'h00};
    @(posedge i_clock);
    cfg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] idx, output logic [15:0] d);
    @(posedge i_clock);
    in_idx <= idx;
    @(posedge i_clock);
    @(negedge i_clock);
    d = in_data;
  endtask
  // Zero handshake, parameter, code, then poll the status until it is set
  task automatic run(input logic [15:0] code, input logic [15:0] p1, input logic [15:0] exp);
    logic [15:0] s;
    int          t;
    wr(4'h0, 16'h0000);
    s = 16'hffff;
    for (t = 0; t < 20 && s !== 16'h0000; t++) rd(4'h0, s);
    chk(s, 16'h0000);
    // A handshake that never settles ends the run
    if (s !== 16'h0000) stop_test();
    wr(4'h1, p1);
    wr(4'h0, code);
    for (t = 0; t < 1500 && s === 16'h0000; t++) rd(4'h0, s);
    if (t == 1500) begin
      bad_count++;
      stop_test();
    end
    chk(s, exp);
    chk({15'h0000, busy}, 16'h0000);
  endtask
  task automatic chk_data(input logic [15:0] c, input int nb, input logic [3:0] idx);
    logic [15:0] w;
    for (int j = 0; j < nb / 2; j++) begin
      rd(idx + 4'(j), w);
      chk(w, {c[7:0] + 8'(2 * j), c[7:0] + 8'(2 * j + 1)});
    end
  endtask
  task automatic chk_err(input logic [15:0] c, input logic [7:0] len);
    logic [15:0] w;
    rd(4'h1, w);
    chk(w, c);
    rd(4'h2, w);
    chk(w, {len, 8'h00});
  endtask
  initial begin
    {i_resetn, out_wr, cfg_wr, nak} <= 4'h0;
    {out_idx, in_idx, slow, rx_mode, cfg_blk, cfg_ent} <= 19'h00000;
    {out_data, cfg_cmd, cfg_len} <= 40'h0000000000;
    bad_count = 0;
    n_tests = 0;
    repeat (6) @(posedge i_clock);
    i_resetn <= 1'b1;
    // Blanket poll against a slow loader
    slow <= 4'h3;
    run(16'h0100, 16'h0000, 16'h0100);
    for (int i = 0; i < 3; i++) begin
      rd(4'(1 + 3 * i), v);
      chk(v, bl[i]);
      chk_data(bl[i], (i == 2) ? 2 : 4, 4'(2 + 3 * i));
    end
    slow <= 4'h0;
    run(16'h0604, 16'h2054, 16'h0604);
    chk_data(16'h2054, 4, 4'h1);
    run(16'h0700, 16'h0000, 16'hff03);
    run(16'h0200, 16'h0000, 16'hff03);
    run(16'h0600, 16'h2054, 16'hff01);
    chk_err(16'h2054, 8'h00);
    // Capacity limits on both sides of each boundary
    run(16'h0615, 16'h2055, 16'hff04);
    chk_err(16'h2055, 8'h15);
    run(16'h0614, 16'h2055, 16'h0614);
    run(16'h0613, 16'h2054, 16'hff05);
    run(16'h0612, 16'h2054, 16'h0612);
    chk_data(16'h2054, 18, 4'h1);
    // Custom poll and select blocks
    cfg(2'h0, 3'h0, 16'h2048);
    cfg(2'h0, 3'h1, 16'h2050);
    cfg(2'h1, 3'h0, 16'h2040);
    cfg(2'h2, 3'h0, 16'h2049);
    cfg(2'h2, 3'h1, 16'h2051);
    cfg(2'h3, 3'h0, 16'h2051);
    run(16'h0200, 16'h0000, 16'h0200);
    chk_data(16'h2048, 2, 4'h1);
    chk_data(16'h2050, 4, 4'h2);
    run(16'h0300, 16'h0000, 16'h0300);
    chk_data(16'h2040, 2, 4'h1);
    wr(4'h2, 16'h5678);
    wr(4'h3, 16'h9abc);
    u_lrh_loader_model.sel_q.delete();
    run(16'h0400, 16'h1234, 16'h0400);
    run(16'h0500, 16'h1234, 16'h0500);
    chk(16'(u_lrh_loader_model.sel_q.size()), 16'h000a);
    for (int i = 0; i < 10; i++) chk({8'h00, u_lrh_loader_model.sel_q[i]}, {8'h00, sx[i]});
    // Loader faults
    nak <= 1'b1;
    run(16'h0604, 16'h2054, 16'hff00);
    chk_err(16'h2054, 8'h04);
    nak <= 1'b0;
    rx_mode <= 2'h1;
    run(16'h0604, 16'h2054, 16'hff02);
    rx_mode <= 2'h2;
    run(16'h0604, 16'h2054, 16'hff06);
    rx_mode <= 2'h3;
    run(16'h0100, 16'h0000, 16'hff06);
    chk_err(16'h2050, 8'h04);
    stop_test();
  end
endmodule
`default_nettype wire
